// ==== src/cbic_top.sv ====
// Processor to system bus glue: phase clocks, start-up, status latch, input select
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "cbic_defines.svh"
// Notes on behaviour
// [RULE1] Dot clock divided by five, six or seven into two non-overlapping phases.
// [RULE2] Bus clock follows phase two by one dot period, at processor rate.
// [RULE3] Ready, reset and hold pass through D flip-flops on bus clock rise.
// [RULE4] Ready input low if either ready line low; undriven lines read high.
// [RULE5] Power-on clear holds processor reset active.
// [RULE6] After clear and no reset request, reset drops on next bus clock.
// [RULE7] Reset release forces one wait; ready returns on the following edge.
// [RULE8] Hold synchroniser keeps tracking during start-up, unaffected by clear.
// [RULE9] Keyboard restart or enabled switch reruns power-on clear.
// [RULE10] Phantom low for four read strobes after clear, when enabled.
// [RULE11] Bus read strobe from processor strobe, or forced by DMA override.
// [RULE12] Control outputs enabled onto bus by control disable, default high.
// [RULE13] Status byte latched mid-sync from sync and inverted phase two.
// [RULE14] Bus taker pulls status disable low to release status lines.
// [RULE15] Data-out drivers on unless input-mode read or external disable.
// [RULE16] Input multiplexer drives processor only during read strobe.
// [RULE17] Select: both high bidir, keyboard, parallel, internal port choices.
// [RULE18] On-board memory selects internal bus; display page overrides to bidir.
// [RULE19] Address drivers enabled by default; address disable turns them off.
module cbic_top
    import cbic_pkg::*;
#(
    parameter int POC_CYCLES = `CBIC_POC_HOLD_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic prdy_n,
    input wire logic xrdy_n,
    input wire logic preset_n,
    input wire logic phold_n,
    input wire logic keyboard_restart_request_n,
    input wire logic dma_read_override_n,
    input wire logic ctrl_bus_enable,
    input wire logic status_bus_enable_n,
    input wire logic data_out_bus_enable_n,
    input wire logic addr_bus_enable_n,
    input wire logic cpu_sync,
    input wire logic cpu_read_strobe,
    input wire logic interrupt_enable_out,
    input wire logic hold_acknowledge,
    input wire logic cpu_write_n,
    input wire logic cpu_wait,
    input wire logic [15:0] cpu_addr,
    input wire logic [7:0] cpu_data_out,
    input wire logic mem_select,
    input wire logic display_memory_page_hit_n,
    input wire logic keyboard_port_read_n,
    input wire logic parallel_port_read_n,
    input wire logic internal_port_select,
    input wire logic [7:0] keyboard_data_bus,
    input wire logic [7:0] parallel_input_bus,
    input wire logic [7:0] internal_data_bus,
    input wire logic [7:0] bidirectional_data_bus,
    output logic phase1,
    output logic phase2,
    output logic bus_clock,
    output logic cpu_ready,
    output logic cpu_reset,
    output logic cpu_hold,
    output logic poc_n,
    output logic phantom_n,
    output logic pdbin,
    output logic [5:0] ctrl_bus_out,
    output logic ctrl_bus_oe,
    output logic [7:0] status_out,
    output logic status_oe,
    output logic [7:0] data_out,
    output logic data_out_oe,
    output logic [15:0] addr_out,
    output logic addr_oe,
    output logic [7:0] cpu_data_in,
    output logic cpu_data_in_oe,
    output logic input_select_lo,
    output logic input_select_hi
);
    localparam int DOT_CYC = (`CBIC_DOT_CYC < 1) ? 1 : `CBIC_DOT_CYC;
    typedef struct packed {
        logic [3:0] dot_cnt;
        logic [3:0] ring;
        logic phase1;
        logic phase2;
        logic bus_clock;
        logic [19:0] poc_cnt;
        logic poc_n;
        logic rst_ff;
        logic rdy_ff;
        logic hold_ff;
        logic [3:0] phantom_sr;
        logic [2:0] strobe_sync;
        logic [7:0] status;
        logic [31:0] ctrl;
        logic [31:0] prdata;
    } cbic_top_s;
    cbic_top_s st, next_st;
    cbic_sync_if sync_bus ();
    logic [2:0] rq;
    logic dot_tick;
    logic bus_rise;
    logic strobe_seen;
    logic read_n;
    logic restart;
    logic poc_stuck_n;
    logic access;
    logic fb;
    logic [1:0] div;
    cbic_sel_e sel;
    initial begin
        if (POC_CYCLES < 1 || POC_CYCLES > 20'hFFFFF) $error("POC_CYCLES out of range");
    end
    cbic_sync3 #(
        .WIDTH(3),
        .INIT(3'h7)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .port(sync_bus.snk)
    );
    assign sync_bus.raw = {phold_n, preset_n, prdy_n & xrdy_n}; // RULE4
    assign rq = sync_bus.clean;
    assign div = st.ctrl[`CBIC_CTRL_DIV_LSB +: 2];
    assign dot_tick = (st.dot_cnt == 4'(DOT_CYC - 1));
    // Request flip-flops take their inputs where the bus clock rises
    assign bus_rise = dot_tick && !st.bus_clock && st.phase2; // RULE3
    assign restart = !keyboard_restart_request_n
        || (st.ctrl[`CBIC_CTRL_SWJ_BIT] && st.ctrl[`CBIC_CTRL_SW_BIT]); // RULE9
    assign access = psel && penable;
    always_comb begin
        // Ring feedback per divide jumper
        case (div)
            `CBIC_DIV5: fb = ~(st.ring[1] & st.ring[2]);
            `CBIC_DIV7: fb = ~(st.ring[2] & st.ring[3]);
            default: fb = ~st.ring[2];
        endcase
    end
    always_comb begin
        if (mem_select || !display_memory_page_hit_n) begin
            if (!display_memory_page_hit_n) begin
                sel = cbic_sel_bidir; // RULE18
            end else begin
                sel = cbic_sel_internal; // RULE18
            end
        end else if (!keyboard_port_read_n) begin
            sel = cbic_sel_keyboard; // RULE17
        end else if (!parallel_port_read_n) begin
            sel = cbic_sel_parallel; // RULE17
        end else if (internal_port_select) begin
            sel = cbic_sel_internal; // RULE17
        end else begin
            sel = cbic_sel_bidir; // RULE17
        end
    end
    always_comb begin
        next_st = st;
        next_st.dot_cnt = dot_tick ? 4'h0 : st.dot_cnt + 4'h1;
        if (dot_tick) begin
            next_st.ring = {st.ring[2:0], fb}; // RULE1
            next_st.phase1 = st.ring[1] & st.ring[3]; // RULE1
            next_st.phase2 = ~(st.ring[1] & st.ring[2]) & ~(st.ring[1] & st.ring[3]); // RULE1
            next_st.bus_clock = st.phase2; // RULE2
        end
        if (restart) begin
            next_st.poc_cnt = 20'h0; // RULE9
            next_st.poc_n = 1'b0;
        end else if (st.poc_cnt != 20'(POC_CYCLES)) begin
            next_st.poc_cnt = st.poc_cnt + 20'h1;
        end else begin
            next_st.poc_n = 1'b1;
        end
        if (bus_rise) begin
            next_st.hold_ff = ~rq[2]; // RULE8
            next_st.rst_ff = st.poc_n ? ~rq[1] : 1'b1; // RULE5 RULE6
            next_st.rdy_ff = rq[0] && !(st.rst_ff && !(st.poc_n ? ~rq[1] : 1'b1)); // RULE7
        end
        if (!st.poc_n) begin
            next_st.rst_ff = 1'b1; // RULE5
            next_st.phantom_sr = 4'h0; // RULE10
        end else if (strobe_seen) begin
            next_st.phantom_sr = {st.phantom_sr[2:0], 1'b1}; // RULE10
        end
        next_st.strobe_sync = {st.strobe_sync[1:0], cpu_read_strobe};
        if (cpu_sync && !st.phase2) begin
            next_st.status = cpu_data_out; // RULE13
        end
        next_st.prdata = 32'h0;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                `CBIC_ADDR_CTRL: next_st.prdata = st.ctrl;
                `CBIC_ADDR_STAT: next_st.prdata = {24'h0, st.poc_n, st.rst_ff, st.rdy_ff,
                    st.hold_ff, st.phantom_sr};
                `CBIC_ADDR_STATUS_BYTE: next_st.prdata = {24'h0, st.status};
                default: next_st.prdata = 32'h0;
            endcase
        end
        if (access && pwrite && paddr == `CBIC_ADDR_CTRL) begin
            next_st.ctrl = {27'h0, pwdata[4:0]};
        end
    end
    // Strobe counted on its falling edge, after the fetch completes
    assign strobe_seen = st.strobe_sync[2] && !st.strobe_sync[1];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.ctrl <= `CBIC_CTRL_RESET;
        end else begin
            st <= next_st;
        end
    end
    assign poc_stuck_n = st.poc_n;
    assign read_n = ~cpu_read_strobe;
    assign pready = 1'b1;
    assign pslverr = access && !(paddr == `CBIC_ADDR_CTRL || paddr == `CBIC_ADDR_STAT
        || paddr == `CBIC_ADDR_STATUS_BYTE || paddr == `CBIC_ADDR_STATUS_BYTE);
    assign prdata = st.prdata;
    assign phase1 = st.phase1;
    assign phase2 = st.phase2;
    assign bus_clock = st.bus_clock;
    assign cpu_ready = st.rdy_ff; // RULE3
    assign cpu_reset = st.rst_ff; // RULE3
    assign cpu_hold = st.hold_ff; // RULE3
    assign poc_n = poc_stuck_n;
    assign phantom_n = !st.ctrl[`CBIC_CTRL_PHJ_BIT] || st.phantom_sr[3]; // RULE10
    assign pdbin = cpu_read_strobe || !dma_read_override_n; // RULE11
    assign ctrl_bus_out = {pdbin, cpu_sync, interrupt_enable_out, hold_acknowledge,
        cpu_write_n, cpu_wait};
    assign ctrl_bus_oe = ctrl_bus_enable; // RULE12
    assign status_out = st.status;
    assign status_oe = status_bus_enable_n; // RULE14
    assign input_select_lo = (sel == cbic_sel_bidir) || (sel == cbic_sel_parallel);
    assign input_select_hi = (sel == cbic_sel_bidir) || (sel == cbic_sel_keyboard);
    assign data_out = cpu_data_out;
    assign data_out_oe = data_out_bus_enable_n
        && !(cpu_read_strobe && sel != cbic_sel_bidir); // RULE15
    assign addr_out = cpu_addr;
    assign addr_oe = addr_bus_enable_n; // RULE19
    assign cpu_data_in_oe = !read_n; // RULE16
    always_comb begin
        case (sel)
            cbic_sel_keyboard: cpu_data_in = keyboard_data_bus;
            cbic_sel_parallel: cpu_data_in = parallel_input_bus;
            cbic_sel_internal: cpu_data_in = internal_data_bus;
            default: cpu_data_in = bidirectional_data_bus;
        endcase
    end
    a_poc_holds_reset: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
        !st.poc_n |=> cpu_reset) else $error("reset not held during clear");
    a_pdbin_follow: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
        cpu_read_strobe |-> pdbin) else $error("bus read strobe missing");
    a_mux_idle: assert property (@(posedge pclk) disable iff (!presetn) // RULE16
        !cpu_read_strobe |-> !cpu_data_in_oe) else $error("mux drives outside read");
    a_display_bidir: assert property (@(posedge pclk) disable iff (!presetn) // RULE18
        !display_memory_page_hit_n |-> input_select_lo && input_select_hi)
        else $error("display page not bidir");
    a_phantom_clear: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
        $rose(st.poc_n) |-> st.phantom_sr == 4'h0) else $error("phantom not cleared");
    a_restart_clear: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
        restart |=> !st.poc_n) else $error("restart ignored");
    a_addr_default: assert property (@(posedge pclk) disable iff (!presetn) // RULE19
        addr_bus_enable_n |-> addr_oe) else $error("address drivers off");
    a_status_latch: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
        cpu_sync && !st.phase2 |=> status_out == $past(cpu_data_out))
        else $error("status not latched");
endmodule // cbic_top

// ==== src/cbic_defines.svh ====
// Constants for the processor bus interface control block
`ifndef CBIC_DEFINES_SVH
`define CBIC_DEFINES_SVH
`define CBIC_DOT_NS 70
`define CBIC_CLK_NS 8
`define CBIC_DOT_CYC ((`CBIC_DOT_NS) / (`CBIC_CLK_NS))
`define CBIC_DIV5 2'h1
`define CBIC_DIV6 2'h0
`define CBIC_DIV7 2'h2
`define CBIC_PHANTOM_FETCHES 4
`define CBIC_POC_HOLD_NS 1000
`define CBIC_POC_HOLD_CYC ((`CBIC_POC_HOLD_NS) / (`CBIC_CLK_NS))
`define CBIC_ADDR_CTRL 12'h000
`define CBIC_ADDR_STAT 12'h004
`define CBIC_ADDR_STATUS_BYTE 12'h008
`define CBIC_CTRL_RESET 32'h0000_0006
`define CBIC_CTRL_DIV_LSB 0
`define CBIC_CTRL_PHJ_BIT 2
`define CBIC_CTRL_SWJ_BIT 3
`define CBIC_CTRL_SW_BIT 4
`endif

// ==== src/cbic_pkg.sv ====
// Types for the processor bus interface control block
package cbic_pkg;
    typedef enum logic [1:0] {
        cbic_sel_internal,
        cbic_sel_keyboard,
        cbic_sel_parallel,
        cbic_sel_bidir
    } cbic_sel_e;
endpackage

// ==== src/cbic_sync_if.sv ====
// Raw bus requests and their synchronised copies
`timescale 1ns/1ps
interface cbic_sync_if;
    logic [2:0] raw;
    logic [2:0] clean;
    modport src (output raw, input clean);
    modport snk (input raw, output clean);
endinterface

// ==== src/cbic_sync3.sv ====
// Three-stage input synchroniser, change taken when stages two and three agree
`timescale 1ns/1ps
module cbic_sync3
    import cbic_pkg::*;
#(
    parameter int WIDTH = 3,
    parameter logic [2:0] INIT = 3'h7
) (
    input wire logic pclk,
    input wire logic presetn,
    cbic_sync_if.snk port
);
    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
        logic [2:0] q;
    } cbic_sync_s;
    cbic_sync_s st, next_st;
    initial begin
        if (WIDTH != 3) $error("cbic_sync3 serves width 3 only");
    end
    always_comb begin
        next_st = st;
        next_st.s1 = port.raw;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < 3; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.q[i] = st.s3[i];
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= {INIT, INIT, INIT, INIT};
        end else begin
            st <= next_st;
        end
    end
    assign port.clean = st.q;
endmodule // cbic_sync3

// ==== bench/cbic_cpu_model.sv ====
// Processor stand-in driving sync, read strobe and data pins
`timescale 1ns/1ps
module cbic_cpu_model (
    input wire logic pclk,
    input wire logic phase2,
    output logic cpu_sync,
    output logic cpu_read_strobe,
    output logic [7:0] cpu_data_out
);
    initial begin
        cpu_sync = 1'h0;
        cpu_read_strobe = 1'h0;
        cpu_data_out = 8'h00;
    end
    task automatic strobe(input logic v);
        @(posedge pclk);
        cpu_read_strobe <= v;
    endtask
    // Strobe kept wide so the synchronised edge is never missed
    task automatic fetch();
        strobe(1'h1);
        repeat (12) @(posedge pclk);
        strobe(1'h0);
        repeat (12) @(posedge pclk);
    endtask
    task automatic ph2_rise();
        @(posedge pclk);
        while (phase2 !== 1'h0) @(posedge pclk);
        while (phase2 !== 1'h1) @(posedge pclk);
    endtask
    task automatic status_cycle(input logic [7:0] s);
        ph2_rise();
        cpu_sync <= 1'h1;
        cpu_data_out <= s;
        ph2_rise();
        cpu_sync <= 1'h0;
        // Lines turn round, so a late latch would see the wrong byte
        cpu_data_out <= ~s;
    endtask
endmodule // cbic_cpu_model

// ==== bench/tb_cpu_bus_interface_control.sv ====
// Testbench for the processor bus interface control block
`timescale 1ns/1ps
`include "cbic_defines.svh"
module tb_cpu_bus_interface_control;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, prdy_n, xrdy_n, preset_n;
    logic phold_n, keyboard_restart_request_n, dma_read_override_n, ctrl_bus_enable;
    logic status_bus_enable_n, data_out_bus_enable_n, addr_bus_enable_n, cpu_sync;
    logic cpu_read_strobe, interrupt_enable_out, hold_acknowledge, cpu_write_n, cpu_wait;
    logic mem_select, display_memory_page_hit_n, keyboard_port_read_n, parallel_port_read_n;
    logic internal_port_select, phase1, phase2, bus_clock, cpu_ready, cpu_reset, cpu_hold;
    logic poc_n, phantom_n, pdbin, ctrl_bus_oe, status_oe, data_out_oe, addr_oe;
    logic cpu_data_in_oe, input_select_lo, input_select_hi;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] cpu_addr, addr_out;
    logic [7:0] cpu_data_out, keyboard_data_bus, parallel_input_bus, internal_data_bus;
    logic [7:0] bidirectional_data_bus, status_out, data_out, cpu_data_in;
    logic [5:0] ctrl_bus_out;
    logic er;
    int miscompares = 0;
    int n_compared = 0;
    cbic_top #(.POC_CYCLES(8)) i_cbic_top (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .prdy_n, .xrdy_n, .preset_n, .phold_n,
        .keyboard_restart_request_n, .dma_read_override_n, .ctrl_bus_enable,
        .status_bus_enable_n, .data_out_bus_enable_n, .addr_bus_enable_n, .cpu_sync,
        .cpu_read_strobe, .interrupt_enable_out, .hold_acknowledge, .cpu_write_n, .cpu_wait,
        .cpu_addr, .cpu_data_out, .mem_select, .display_memory_page_hit_n,
        .keyboard_port_read_n, .parallel_port_read_n, .internal_port_select,
        .keyboard_data_bus, .parallel_input_bus, .internal_data_bus, .bidirectional_data_bus,
        .phase1, .phase2, .bus_clock, .cpu_ready, .cpu_reset, .cpu_hold, .poc_n, .phantom_n,
        .pdbin, .ctrl_bus_out, .ctrl_bus_oe, .status_out, .status_oe, .data_out, .data_out_oe,
        .addr_out, .addr_oe, .cpu_data_in, .cpu_data_in_oe, .input_select_lo, .input_select_hi);
    cbic_cpu_model i_cbic_cpu_model (.pclk, .phase2, .cpu_sync, .cpu_read_strobe,
        .cpu_data_out);
    initial begin
        pclk = 1'h0;
        forever #4 pclk = ~pclk;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task automatic wait_poc();
        int i;
        i = 0;
        while (poc_n !== 1'h1 && i < 400) begin
            @(posedge pclk);
            i++;
        end
        chk("poc_release", i < 400, 32'h1);
    endtask
    task automatic t_start();
        int i;
        @(posedge pclk);
        #1;
        chk("cpu_reset", {poc_n, cpu_reset}, 32'h1);
        wait_poc();
        i = 0;
        while (cpu_reset !== 1'h0 && i < 64) begin
            @(posedge pclk);
            i++;
        end
        chk("reset_drop", i < 64, 32'h1);
        chk("cpu_ready", cpu_ready, 32'h0);
        i = 0;
        while (cpu_ready !== 1'h1 && i < 100) begin
            @(posedge pclk);
            i++;
        end
        chk("ready_back", i > 8 && i <= 64, 32'h1);
    endtask
    task automatic t_phantom();
        chk("phantom_n", phantom_n, 32'h0);
        repeat (3) i_cbic_cpu_model.fetch();
        chk("phantom_n", phantom_n, 32'h0);
        i_cbic_cpu_model.fetch();
        chk("phantom_n", phantom_n, 32'h1);
    endtask
    task automatic t_status();
        i_cbic_cpu_model.status_cycle(8'hA5);
        repeat (2) @(posedge pclk);
        chk("status_out", {status_oe, status_out}, 32'h1A5);
        apb(1'h0, `CBIC_ADDR_STATUS_BYTE, 32'h0);
        chk("status_byte", rd, 32'h0000_00A5);
        status_bus_enable_n <= 1'h0;
        @(posedge pclk);
        #1;
        chk("status_oe", status_oe, 32'h0);
        status_bus_enable_n <= 1'h1;
    endtask
    // Each entry: restart-free select inputs, then expected select levels hi, lo
    task automatic t_mux();
        logic [6:0] tbl [6] = '{7'h67, 7'h26, 7'h45, 7'h74, 7'h6C, 7'h6B};
        logic [7:0] srcs [4] = '{8'hC3, 8'hB2, 8'hA1, 8'hD4};
        i_cbic_cpu_model.strobe(1'h1);
        foreach (tbl[k]) begin
            @(posedge pclk);
            {keyboard_port_read_n, parallel_port_read_n, internal_port_select, mem_select,
                display_memory_page_hit_n} <= tbl[k][6:2];
            @(posedge pclk);
            #1;
            chk("cpu_data_in", cpu_data_in, srcs[tbl[k][1:0]]);
            chk("select", {input_select_hi, input_select_lo}, tbl[k][1:0]);
            chk("mux_oe", cpu_data_in_oe, 32'h1);
        end
        i_cbic_cpu_model.strobe(1'h0);
        @(posedge pclk);
        #1;
        chk("mux_oe", cpu_data_in_oe, 32'h0);
    endtask
    task automatic t_drv(input logic v);
        @(posedge pclk);
        {dma_read_override_n, ctrl_bus_enable, addr_bus_enable_n,
            data_out_bus_enable_n} <= {4{v}};
        @(posedge pclk);
        #1;
        chk("pdbin", pdbin, !v);
        chk("ctrl_oe", ctrl_bus_oe, v);
        chk("ctrl_bus_out", ctrl_bus_out, {!v, 5'h02});
        chk("addr_oe", {addr_oe, addr_out}, {v, 16'hC0DE});
        chk("data_out", {data_out_oe, data_out}, {v, 8'h5A});
    endtask
    task automatic t_clk();
        int dv [3] = '{5, 6, 7};
        logic [1:0] cd [3] = '{`CBIC_DIV5, `CBIC_DIV6, `CBIC_DIV7};
        int n, ov;
        foreach (dv[k]) begin
            apb(1'h1, `CBIC_ADDR_CTRL, {30'h1, cd[k]});
            repeat (2) begin
                {n, ov} = 64'h0;
                while (bus_clock !== 1'h0) @(posedge pclk);
                while (bus_clock !== 1'h1) @(posedge pclk);
                do begin
                    @(posedge pclk);
                    n++;
                    ov += phase1 & phase2;
                end while (bus_clock !== 1'h0);
                while (bus_clock !== 1'h1) begin
                    @(posedge pclk);
                    n++;
                end
            end
            chk("bus_clock_period", n, dv[k] * `CBIC_DOT_CYC);
            chk("phase_overlap", ov, 32'h0);
        end
    endtask
    task automatic t_restart(input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        phold_n <= 1'h0;
        if (d == 32'h0) keyboard_restart_request_n <= 1'h0;
        else apb(1'h1, a, d);
        repeat (120) @(posedge pclk);
        #1;
        chk("restart", {poc_n, cpu_reset, cpu_hold}, 32'h3);
        keyboard_restart_request_n <= 1'h1;
        apb(1'h1, `CBIC_ADDR_CTRL, `CBIC_CTRL_RESET);
        phold_n <= 1'h1;
        wait_poc();
        chk("phantom_n", phantom_n, 32'h0);
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = 48'h0;
        {prdy_n, xrdy_n, preset_n, phold_n, keyboard_restart_request_n} = 5'h1F;
        {dma_read_override_n, ctrl_bus_enable, status_bus_enable_n} = 3'h7;
        {data_out_bus_enable_n, addr_bus_enable_n, display_memory_page_hit_n} = 3'h7;
        {keyboard_port_read_n, parallel_port_read_n, internal_port_select, mem_select} = 4'hC;
        {interrupt_enable_out, hold_acknowledge, cpu_write_n, cpu_wait} = 4'h2;
        {cpu_addr, keyboard_data_bus, parallel_input_bus} = 32'hC0DE_A1B2;
        {internal_data_bus, bidirectional_data_bus} = 16'hC3D4;
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        t_start();
        t_phantom();
        t_status();
        t_mux();
        t_drv(1'h0);
        t_drv(1'h1);
        apb(1'h0, `CBIC_ADDR_CTRL, 32'h0);
        chk("ctrl_reset", rd, `CBIC_CTRL_RESET);
        apb(1'h0, `CBIC_ADDR_STAT, 32'h0);
        chk("stat", rd, 32'h0000_00AF);
        apb(1'h0, 12'h00C, 32'h0);
        chk("unmapped_err", {31'h0, er}, 32'h1);
        chk("unmapped", rd, 32'h0);
        t_clk();
        t_restart(`CBIC_ADDR_CTRL, 32'h0);
        t_restart(`CBIC_ADDR_CTRL, 32'h1E);
        prdy_n <= 1'h0;
        repeat (120) @(posedge pclk);
        chk("cpu_ready", cpu_ready, 32'h0);
        {prdy_n, xrdy_n} <= 2'h2;
        repeat (120) @(posedge pclk);
        chk("cpu_ready", cpu_ready, 32'h0);
        xrdy_n <= 1'h1;
        repeat (120) @(posedge pclk);
        chk("cpu_ready", cpu_ready, 32'h1);
        complete_run();
    end
    initial begin
        #(8 * 30000);
        miscompares++;
        complete_run();
    end
endmodule // tb_cpu_bus_interface_control
